// File: hdl/lipi_pkg.sv
// Constants and types for the local interrupt pin interface.
// Assumes one core clock; every pin arrives asynchronously to it.
// How it works
// [RULE1] Controller off: local input zero drives the maskable interrupt request.
// [RULE2] Controller off: local input one raises a nonmaskable interrupt.
// [RULE3] Both local inputs are asynchronous, with no timing tie to any clock.
// [RULE4] Input role changes only through a software write to controller config.
// [RULE5] Controller is enabled after reset, so inputs act as controller inputs.
// [RULE6] Messages pass serially, both ways, over the two interrupt bus data lines.
// [RULE7] System supplies one common interrupt bus clock to all bus agents.
// [RULE8] Each asynchronous input passes two flip-flops before any logic reads it.
package lipi_pkg;
    localparam int LIPI_MSG_W = 32;
    localparam int LIPI_SYNC_STAGES = 2;
    localparam logic LIPI_CTRL_EN_RST = 1'b1;
    localparam logic [1:0] LIPI_BUS_IDLE = 2'h3;
    localparam logic [1:0] LIPI_BUS_START = 2'h0;
    localparam int LIPI_TX_START_MAX = 200;

    typedef enum logic [1:0] {
        LIPI_TX_IDLE,
        LIPI_TX_START,
        LIPI_TX_DATA
    } lipi_tx_state_t;

    typedef enum logic [1:0] {
        LIPI_RX_IDLE,
        LIPI_RX_DATA
    } lipi_rx_state_t;
endpackage

// File: hdl/lipi_msg_if.sv
// Carrier between the pin interface top and its serial message engine.
// Assumes both ends run on the same core clock.
`timescale 1ns/10ps
interface lipi_msg_if #(
    parameter int MSG_W = 32
);
    logic tx_valid;
    logic tx_ready;
    logic [MSG_W-1:0] tx_data;
    logic rx_valid;
    logic [MSG_W-1:0] rx_data;
    logic clk_rise;
    logic clk_fall;
    logic [1:0] bus_in;
    logic [1:0] bus_oe;

    modport top (
        output tx_valid,
        input tx_ready,
        output tx_data,
        input rx_valid,
        input rx_data,
        output clk_rise,
        output clk_fall,
        output bus_in,
        input bus_oe
    );

    modport serdes (
        input tx_valid,
        output tx_ready,
        input tx_data,
        output rx_valid,
        output rx_data,
        input clk_rise,
        input clk_fall,
        input bus_in,
        output bus_oe
    );
endinterface

// File: hdl/lipi_msg_serdes.sv
// Serial message engine for the two-line open-drain interrupt bus.
// Assumes bus clock edges and line levels arrive already synchronised.
`timescale 1ns/10ps
module lipi_msg_serdes
    import lipi_pkg::*;
#(
    parameter int MSG_W = LIPI_MSG_W
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    lipi_msg_if.serdes msg
);
    localparam int PAIRS = MSG_W / 2;
    localparam int CNT_W = $clog2(PAIRS + 1);
    localparam logic [CNT_W-1:0] LAST_PAIR = CNT_W'(PAIRS - 1);

    // Pairs go out two bits at a time, so an odd width cannot be framed
    if (MSG_W < 4 || (MSG_W % 2) != 0) begin : g_bad_width
        $error("Message width must be even and at least 4");
    end

    lipi_tx_state_t tx_state_ff, nxt_tx_state;
    logic [MSG_W-1:0] tx_shift_ff, nxt_tx_shift;
    logic [CNT_W-1:0] tx_cnt_ff, nxt_tx_cnt;
    logic [1:0] oe_ff, nxt_oe;
    lipi_rx_state_t rx_state_ff, nxt_rx_state;
    logic [MSG_W-1:0] rx_shift_ff, nxt_rx_shift;
    logic [CNT_W-1:0] rx_cnt_ff, nxt_rx_cnt;
    logic [MSG_W-1:0] rx_data_ff, nxt_rx_data;
    logic rx_valid_ff, nxt_rx_valid;

    // Start only while the receiver is idle; no arbitration against other agents
    assign msg.tx_ready = (tx_state_ff == LIPI_TX_IDLE) && (rx_state_ff == LIPI_RX_IDLE);
    assign msg.bus_oe = oe_ff;
    assign msg.rx_valid = rx_valid_ff;
    assign msg.rx_data = rx_data_ff;

    // Transmit: lines change on bus clock falls; a 0 is driven, a 1 released
    always_comb begin
        nxt_tx_state = tx_state_ff;
        nxt_tx_shift = tx_shift_ff;
        nxt_tx_cnt = tx_cnt_ff;
        nxt_oe = oe_ff;
        case (tx_state_ff)
            LIPI_TX_IDLE: begin
                nxt_oe = 2'h0;
                if (msg.tx_valid && msg.tx_ready) begin
                    nxt_tx_shift = msg.tx_data;
                    nxt_tx_state = LIPI_TX_START;
                end
            end
            LIPI_TX_START: begin
                if (msg.clk_fall) begin
                    nxt_oe = ~LIPI_BUS_START; // RULE6
                    nxt_tx_cnt = '0;
                    nxt_tx_state = LIPI_TX_DATA;
                end
            end
            default: begin
                if (msg.clk_fall) begin
                    if (tx_cnt_ff == CNT_W'(PAIRS)) begin
                        nxt_oe = 2'h0;
                        nxt_tx_state = LIPI_TX_IDLE;
                    end else begin
                        nxt_oe = ~tx_shift_ff[MSG_W-1 -: 2]; // RULE6
                        nxt_tx_shift = {tx_shift_ff[MSG_W-3:0], 2'h0};
                        nxt_tx_cnt = tx_cnt_ff + CNT_W'(1);
                    end
                end
            end
        endcase
    end

    // Receive: sample on bus clock rises; both lines low while idle marks a start
    always_comb begin
        nxt_rx_state = rx_state_ff;
        nxt_rx_shift = rx_shift_ff;
        nxt_rx_cnt = rx_cnt_ff;
        nxt_rx_data = rx_data_ff;
        nxt_rx_valid = 1'b0;
        case (rx_state_ff)
            LIPI_RX_IDLE: begin
                if (msg.clk_rise && msg.bus_in == LIPI_BUS_START
                    && tx_state_ff == LIPI_TX_IDLE) begin
                    nxt_rx_cnt = '0;
                    nxt_rx_state = LIPI_RX_DATA;
                end
            end
            default: begin
                if (msg.clk_rise) begin
                    nxt_rx_shift = {rx_shift_ff[MSG_W-3:0], msg.bus_in}; // RULE6
                    nxt_rx_cnt = rx_cnt_ff + CNT_W'(1);
                    if (rx_cnt_ff == LAST_PAIR) begin
                        nxt_rx_data = {rx_shift_ff[MSG_W-3:0], msg.bus_in};
                        nxt_rx_valid = 1'b1;
                        nxt_rx_state = LIPI_RX_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            tx_state_ff <= LIPI_TX_IDLE;
            tx_shift_ff <= '0;
            tx_cnt_ff <= '0;
            oe_ff <= 2'h0;
            rx_state_ff <= LIPI_RX_IDLE;
            rx_shift_ff <= '0;
            rx_cnt_ff <= '0;
            rx_data_ff <= '0;
            rx_valid_ff <= 1'b0;
        end else begin
            tx_state_ff <= nxt_tx_state;
            tx_shift_ff <= nxt_tx_shift;
            tx_cnt_ff <= nxt_tx_cnt;
            oe_ff <= nxt_oe;
            rx_state_ff <= nxt_rx_state;
            rx_shift_ff <= nxt_rx_shift;
            rx_cnt_ff <= nxt_rx_cnt;
            rx_data_ff <= nxt_rx_data;
            rx_valid_ff <= nxt_rx_valid;
        end
    end

    AST_TX_START_DRIVES_LOW: assert property ( // RULE6
        @(posedge ref_clk_i) disable iff (reset_i)
        (tx_state_ff == LIPI_TX_START && msg.clk_fall) |=> (oe_ff == 2'h3)
    ) else $error("Start of message did not pull both lines low");

    AST_RX_VALID_ONE_CYCLE: assert property ( // RULE6
        @(posedge ref_clk_i) disable iff (reset_i)
        rx_valid_ff |=> !rx_valid_ff && rx_state_ff == LIPI_RX_IDLE
    ) else $error("Received message strobe longer than one cycle");
endmodule

// File: hdl/lipi_top.sv
// Local interrupt pin interface: input role steering and interrupt bus port.
// Assumes all pins are asynchronous to ref_clk_i; config writes come from
// core logic on ref_clk_i.
`timescale 1ns/10ps
module lipi_top
    import lipi_pkg::*;
#(
    parameter int MSG_W = LIPI_MSG_W
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [1:0] local_interrupt_inputs_i,
    input wire logic cfg_write_i,
    input wire logic cfg_controller_enable_i,
    output logic controller_enabled_o,
    output logic local_interrupt_input_zero_o,
    output logic local_interrupt_input_one_o,
    output logic [1:0] local_interrupt_rise_o,
    output logic maskable_interrupt_request_o,
    output logic nonmaskable_interrupt_o,
    input wire logic interrupt_bus_clock_i,
    input wire logic [1:0] interrupt_bus_data_i,
    output logic [1:0] interrupt_bus_data_o,
    output logic [1:0] interrupt_bus_data_oe_o,
    input wire logic msg_tx_valid_i,
    input wire logic [MSG_W-1:0] msg_tx_data_i,
    output logic msg_tx_ready_o,
    output logic msg_rx_valid_o,
    output logic [MSG_W-1:0] msg_rx_data_o
);
    // Pins in one vector: two interrupt inputs, bus clock, two data lines
    localparam int NPIN = 5;
    // Longest wait from acceptance to start pair; one bus clock period fits easily
    localparam int START_WAIT_MAX = LIPI_TX_START_MAX;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1_ff, sync2_ff;
    logic [NPIN-1:0] nxt_sync1, nxt_sync2;
    logic [1:0] lint_s, lint_prev_ff, nxt_lint_prev;
    logic clk_s, clk_prev_ff, nxt_clk_prev;
    logic en_ff, nxt_en;
    logic [1:0] lvl_ff, nxt_lvl;
    logic [1:0] rise_ff, nxt_rise;
    logic maskable_interrupt_request_ff, nxt_maskable_interrupt_request;
    logic nmi_ff, nxt_nmi;

    // The sync chain below is written out for exactly two stages
    if (MSG_W < 4 || (MSG_W % 2) != 0 || LIPI_SYNC_STAGES != 2) begin : g_bad_config
        $error("Message width must be even and at least 4, sync depth two");
    end

    lipi_msg_if #(.MSG_W(MSG_W)) msg ();

    lipi_msg_serdes #(.MSG_W(MSG_W)) u_serdes (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .msg(msg.serdes)
    );

    assign pin_raw = {interrupt_bus_data_i, interrupt_bus_clock_i, local_interrupt_inputs_i};

    // Two flops per pin; only the second stage is read beyond here
    always_comb begin
        nxt_sync1 = pin_raw; // RULE3
        nxt_sync2 = sync1_ff; // RULE8
    end

    assign lint_s = sync2_ff[1:0];
    assign clk_s = sync2_ff[2];

    always_comb begin
        nxt_lint_prev = lint_s;
        nxt_clk_prev = clk_s;
        // Role changes only on an explicit config write
        nxt_en = cfg_write_i ? cfg_controller_enable_i : en_ff; // RULE4
        nxt_lvl = en_ff ? lint_s : 2'h0; // RULE5
        nxt_rise = en_ff ? (lint_s & ~lint_prev_ff) : 2'h0; // RULE5
        nxt_maskable_interrupt_request = !en_ff && lint_s[0]; // RULE1
        // Nonmaskable is edge-sensitive, so a held line gives one pulse
        nxt_nmi = !en_ff && lint_s[1] && !lint_prev_ff[1]; // RULE2
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            lint_prev_ff <= 2'h0;
            clk_prev_ff <= 1'b0;
            en_ff <= LIPI_CTRL_EN_RST; // RULE5
            lvl_ff <= 2'h0;
            rise_ff <= 2'h0;
            maskable_interrupt_request_ff <= 1'b0;
            nmi_ff <= 1'b0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            lint_prev_ff <= nxt_lint_prev;
            clk_prev_ff <= nxt_clk_prev;
            en_ff <= nxt_en;
            lvl_ff <= nxt_lvl;
            rise_ff <= nxt_rise;
            maskable_interrupt_request_ff <= nxt_maskable_interrupt_request;
            nmi_ff <= nxt_nmi;
        end
    end

    // Bus clock edges found by sampling; the bench clock is far slower than ours
    assign msg.clk_rise = clk_s && !clk_prev_ff;
    assign msg.clk_fall = !clk_s && clk_prev_ff;
    assign msg.bus_in = sync2_ff[4:3]; // RULE6
    assign msg.tx_valid = msg_tx_valid_i;
    assign msg.tx_data = msg_tx_data_i;

    assign controller_enabled_o = en_ff;
    assign local_interrupt_input_zero_o = lvl_ff[0];
    assign local_interrupt_input_one_o = lvl_ff[1];
    assign local_interrupt_rise_o = rise_ff;
    assign maskable_interrupt_request_o = maskable_interrupt_request_ff;
    assign nonmaskable_interrupt_o = nmi_ff;
    // Open drain: only ever pulls low
    assign interrupt_bus_data_o = 2'h0;
    assign interrupt_bus_data_oe_o = msg.bus_oe;
    assign msg_tx_ready_o = msg.tx_ready;
    assign msg_rx_valid_o = msg.rx_valid;
    assign msg_rx_data_o = msg.rx_data;

    AST_MASKABLE_INTERRUPT_REQUEST_FOLLOWS_ZERO: assert property ( // RULE1
        @(posedge ref_clk_i) disable iff (reset_i)
        !en_ff ##1 !en_ff |-> maskable_interrupt_request_o == $past(lint_s[0])
    ) else $error("Maskable request does not track local input zero");

    AST_NMI_ON_RISE: assert property ( // RULE2
        @(posedge ref_clk_i) disable iff (reset_i)
        (!en_ff && lint_s[1] && !lint_prev_ff[1]) |=> nonmaskable_interrupt_o ##1
        !nonmaskable_interrupt_o
    ) else $error("Nonmaskable interrupt not a single pulse on input one rise");

    AST_LEVEL_LATENCY: assert property ( // RULE8
        @(posedge ref_clk_i) disable iff (reset_i)
        $past(en_ff) && $past(!reset_i, 3) |->
        local_interrupt_input_one_o == $past(local_interrupt_inputs_i[1], 3)
    ) else $error("Local input does not reach output after three cycles");

    AST_ASYNC_NO_GLITCH: assert property ( // RULE3
        @(posedge ref_clk_i) disable iff (reset_i)
        $changed(local_interrupt_inputs_i[0]) && en_ff ##1 en_ff |->
        $stable(local_interrupt_input_zero_o)
    ) else $error("Asynchronous input reached logic without synchronisation");

    AST_ROLE_BY_WRITE_ONLY: assert property ( // RULE4
        @(posedge ref_clk_i) disable iff (reset_i)
        !cfg_write_i |=> $stable(controller_enabled_o)
    ) else $error("Input role changed without a config write");

    AST_ENABLED_AFTER_RESET: assert property ( // RULE5
        @(posedge ref_clk_i)
        reset_i |=> controller_enabled_o && !maskable_interrupt_request_o
    ) else $error("Controller not enabled after reset");

    AST_ENABLED_BLOCKS_LEGACY: assert property ( // RULE5
        @(posedge ref_clk_i) disable iff (reset_i)
        en_ff |=> !maskable_interrupt_request_o && !nonmaskable_interrupt_o
    ) else $error("Legacy interrupt raised while controller enabled");

    // Bus checks below assume the bus clock keeps running, as every agent needs
    AST_ROLE_TAKES_WRITE: assert property ( // RULE4
        @(posedge ref_clk_i) disable iff (reset_i)
        cfg_write_i |=> controller_enabled_o == $past(cfg_controller_enable_i)
    ) else $error("Config write did not set the input role");

    AST_RISE_NEEDS_ENABLE: assert property ( // RULE5
        @(posedge ref_clk_i) disable iff (reset_i)
        (|local_interrupt_rise_o) |-> $past(en_ff)
    ) else $error("Controller edge pulse while controller disabled");

    AST_LEVELS_OFF_WHEN_DISABLED: assert property ( // RULE1
        @(posedge ref_clk_i) disable iff (reset_i)
        !$past(en_ff) |->
        !local_interrupt_input_zero_o && !local_interrupt_input_one_o
    ) else $error("Controller inputs driven while controller disabled");

    AST_NMI_SINGLE_PULSE: assert property ( // RULE2
        @(posedge ref_clk_i) disable iff (reset_i)
        nonmaskable_interrupt_o |=> !nonmaskable_interrupt_o
    ) else $error("Nonmaskable interrupt longer than one cycle");

    AST_RISE_ZERO_SINGLE_PULSE: assert property ( // RULE5
        @(posedge ref_clk_i) disable iff (reset_i)
        local_interrupt_rise_o[0] |=> !local_interrupt_rise_o[0]
    ) else $error("Edge pulse of input zero longer than one cycle");

    AST_RISE_ONE_SINGLE_PULSE: assert property ( // RULE5
        @(posedge ref_clk_i) disable iff (reset_i)
        local_interrupt_rise_o[1] |=> !local_interrupt_rise_o[1]
    ) else $error("Edge pulse of input one longer than one cycle");

    AST_IDLE_LINES_RELEASED: assert property ( // RULE6
        @(posedge ref_clk_i) disable iff (reset_i)
        msg_tx_ready_o |-> interrupt_bus_data_oe_o == ~LIPI_BUS_IDLE
    ) else $error("Bus line pulled low while no message is being sent");

    AST_READY_DROPS_ON_ACCEPT: assert property ( // RULE6
        @(posedge ref_clk_i) disable iff (reset_i)
        msg_tx_valid_i && msg_tx_ready_o |=> !msg_tx_ready_o
    ) else $error("Message accepted but sender still ready");

    AST_START_AFTER_ACCEPT: assert property ( // RULE6
        @(posedge ref_clk_i) disable iff (reset_i)
        (msg_tx_valid_i && msg_tx_ready_o) |->
        ##[1:START_WAIT_MAX] interrupt_bus_data_oe_o == 2'h3
    ) else $error("Start pair not driven after message acceptance");

    AST_RX_DATA_ONLY_WITH_VALID: assert property ( // RULE6
        @(posedge ref_clk_i) disable iff (reset_i)
        $changed(msg_rx_data_o) |-> msg_rx_valid_o
    ) else $error("Received data changed without a message strobe");

    AST_LEVEL_ZERO_LATENCY: assert property ( // RULE8
        @(posedge ref_clk_i) disable iff (reset_i)
        $past(en_ff) && $past(!reset_i, 3) |->
        local_interrupt_input_zero_o == $past(local_interrupt_inputs_i[0], 3)
    ) else $error("Local input zero does not reach output after three cycles");
endmodule

// File: test/lipi_partner.sv
// Far-side interrupt bus agent: bus clock source, wire resolver, sender, receiver.
// Assumes the device pulls a line low while its enable is high.
`timescale 1ns/10ps
module lipi_partner
    import lipi_pkg::*;
#(
    parameter int MSG_W = LIPI_MSG_W
) (
    input wire logic [1:0] dut_oe_i,
    output logic bus_clk_o,
    output logic [1:0] bus_wire_o
);
    logic [1:0] oe = 2'h0;
    logic sending = 1'b0;
    logic [MSG_W-1:0] rx_msg = '0;
    int rx_count = 0;

    // Shared clock runs free so every agent can frame messages
    initial begin
        bus_clk_o = 1'b0;
        forever #80 bus_clk_o = ~bus_clk_o;
    end

    // Open drain with pull-up: any enable pulls the line low
    assign bus_wire_o = ~(dut_oe_i | oe);

    task automatic send(input logic [MSG_W-1:0] m);
        @(negedge bus_clk_o);
        sending = 1'b1;
        oe <= 2'h3;
        for (int i = MSG_W - 2; i >= 0; i -= 2) begin
            @(negedge bus_clk_o);
            oe <= ~m[i+:2];
        end
        @(negedge bus_clk_o);
        oe <= 2'h0;
        sending = 1'b0;
    endtask

    // Own start pair is ignored while sending
    always begin
        @(posedge bus_clk_o);
        if (!sending && bus_wire_o === 2'h0) begin
            for (int i = MSG_W - 2; i >= 0; i -= 2) begin
                @(posedge bus_clk_o);
                rx_msg[i+:2] = bus_wire_o;
            end
            rx_count++;
        end
    end
endmodule

// File: test/test_lipi_top.sv
// Self-checking bench for the local interrupt pin interface top.
// Assumes the partner model makes the bus clock and resolves the bus wire.
`timescale 1ns/10ps
module test_lipi_top;
    import lipi_pkg::*;
    logic clk, rst, cfg_we, cfg_en, tx_valid;
    logic en_o, lvl0, lvl1, maskable_interrupt_request, nmi, tx_ready, rx_valid, bus_clk;
    logic [1:0] pins, rise, bus_o, bus_oe, bus_wire;
    logic [31:0] tx_data, rx_data;
    int n_errors = 0;
    int checked = 0;
    int cnt, cnt_nmi;

    lipi_top i_lipi_top (.ref_clk_i(clk), .reset_i(rst), .local_interrupt_inputs_i(pins),
        .cfg_write_i(cfg_we), .cfg_controller_enable_i(cfg_en), .controller_enabled_o(en_o),
        .local_interrupt_input_zero_o(lvl0), .local_interrupt_input_one_o(lvl1),
        .local_interrupt_rise_o(rise), .maskable_interrupt_request_o(maskable_interrupt_request),
        .nonmaskable_interrupt_o(nmi), .interrupt_bus_clock_i(bus_clk),
        .interrupt_bus_data_i(bus_wire), .interrupt_bus_data_o(bus_o),
        .interrupt_bus_data_oe_o(bus_oe), .msg_tx_valid_i(tx_valid), .msg_tx_data_i(tx_data),
        .msg_tx_ready_o(tx_ready), .msg_rx_valid_o(rx_valid), .msg_rx_data_o(rx_data));
    lipi_partner i_lipi_partner (.dut_oe_i(bus_oe), .bus_clk_o(bus_clk), .bus_wire_o(bus_wire));

    task automatic end_of_test();
        if (n_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_up(input logic bad);
        if (bad) begin
            n_errors++;
            end_of_test();
        end
    endtask

    task automatic set_pin(input int i, input logic v);
        @(posedge clk);
        pins[i] <= v;
    endtask

    task automatic write_cfg(input logic v);
        @(posedge clk);
        cfg_we <= 1'b1;
        cfg_en <= v;
        @(posedge clk);
        cfg_we <= 1'b0;
        @(negedge clk);
    endtask

    // Counts rise pulses of one input and nmi pulses over n cycles
    task automatic pulses(input int sel, input int n);
        cnt = 0;
        cnt_nmi = 0;
        repeat (n) begin
            @(negedge clk);
            cnt += int'(rise[sel] === 1'b1);
            cnt_nmi += int'(nmi === 1'b1);
        end
    endtask

    task automatic t_reset();
        @(negedge clk);
        check("enabled", en_o, 1'b1);
        check("outs", {lvl0, lvl1, rise, maskable_interrupt_request, nmi}, 6'h00);
        check("ready", tx_ready, 1'b1);
        check("bus", {bus_o, bus_oe}, 4'h0);
    endtask

    task automatic t_enabled();
        set_pin(0, 1'b1);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("sync_lvl0", lvl0, 1'b0);
        pulses(0, 6);
        check("rise0", cnt, 1);
        check("lvl0", lvl0, 1'b1);
        check("maskable_interrupt_request_en", maskable_interrupt_request, 1'b0);
        set_pin(1, 1'b1);
        pulses(1, 6);
        check("rise1", cnt, 1);
        check("nmi_en", cnt_nmi, 0);
        check("lvl1", lvl1, 1'b1);
        set_pin(1, 1'b0);
        pulses(0, 6);
    endtask

    task automatic t_disable();
        write_cfg(1'b0);
        check("disabled", en_o, 1'b0);
        pulses(0, 4);
        check("maskable_interrupt_request", maskable_interrupt_request, 1'b1);
        check("lvl0_dis", lvl0, 1'b0);
        set_pin(0, 1'b0);
        pulses(0, 6);
        check("maskable_interrupt_request_low", maskable_interrupt_request, 1'b0);
        for (int k = 0; k < 2; k++) begin
            set_pin(1, 1'b1);
            pulses(1, 8);
            check("nmi", cnt_nmi, 1);
            check("rise1_dis", cnt, 0);
            check("lvl1_dis", lvl1, 1'b0);
            set_pin(1, 1'b0);
            pulses(1, 4);
        end
        check("still_dis", en_o, 1'b0);
        set_pin(0, 1'b1);
        write_cfg(1'b1);
        check("reenabled", en_o, 1'b1);
        pulses(0, 6);
        check("maskable_interrupt_request_off", {maskable_interrupt_request, lvl0}, 2'h1);
    endtask

    task automatic t_send(input logic [31:0] m);
        int base;
        logic r;
        base = i_lipi_partner.rx_count;
        r = 1'b0;
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_data <= m;
        for (int i = 0; i < 100 && !r; i++) begin
            @(negedge clk);
            r = tx_ready;
            @(posedge clk);
        end
        tx_valid <= 1'b0;
        give_up(!r);
        @(negedge clk);
        check("busy", tx_ready, 1'b0);
        for (int i = 0; i < 1000 && i_lipi_partner.rx_count == base; i++) @(negedge clk);
        give_up(i_lipi_partner.rx_count == base);
        check("sent", i_lipi_partner.rx_msg, m);
        check("drive0", bus_o, 2'h0);
    endtask

    task automatic t_recv(input logic [31:0] m);
        fork
            i_lipi_partner.send(m);
            begin
                for (int i = 0; i < 1000 && rx_valid !== 1'b1; i++) @(negedge clk);
                give_up(rx_valid !== 1'b1);
                check("received", rx_data, m);
            end
        join
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        cfg_we = 1'b0;
        cfg_en = 1'b0;
        tx_valid = 1'b0;
        tx_data = 32'h0;
        pins = 2'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_enabled();
        t_disable();
        t_send(32'hC3A50F96);
        t_send(32'h00FF3C01);
        t_recv(32'h5A0F00E7);
        t_recv(32'hFF00C381);
        end_of_test();
    end
endmodule
